//--- verilog/synth_loader_device.sv
/*
  Device end: serial shift register on the link clock, strobe-driven
  word latch, double-buffered reference and phase registers, fast-lock timers and the
  multiplexed status pin on sys_clk.
  Assumes the host keeps the serial clock still while the strobe is high,
  so the shifted word is quiet when the sys_clk side copies it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "synth_loader_cfg.svh"
// Overview of operation
// R1: sample data on every serial clock rise
// R2: strobe rise latches last 24 bits
// R3: host keeps serial clock at most 33 MHz
// R4: host drops strobe before shifting any bit
// R5: host sends three bytes, then raises strobe
// R6: host drives data valid at rising edge
// R7: output inactive until init writes complete
// R8: status pin carries lock indication when selected
// R9: pump current cuts at its timer, before switches
// R10: bandwidth wide by eight, restored at timers
// R11: frequency write starts fast-lock sequence
// R12: reference and phase apply on frequency write
// R13: first bit is MSB; low bits address
// R14: shifting touches only the shift register
module synth_loader_device (
  input wire logic sys_clk,
  input wire logic resetn,
  synth_link_if.device link,
  input wire logic lock_detect_in,
  output logic [20:0] frequency_word,
  output logic [20:0] reference_word,
  output logic [20:0] phase_word,
  output logic fast_lock_active,
  output logic pump_current_reduced,
  output logic filter_switch_one,
  output logic filter_switch_two,
  output logic filter_switch_three,
  output logic [3:0] bandwidth_factor,
  output logic output_active
);
  // link domain
  logic [23:0] shift_r, shift_nxt;

  // strobe synchroniser and latch
  logic [2:0] strobe_sync_r;
  logic strobe_lvl_r, strobe_lvl_nxt;
  logic latch_pulse;
  logic [23:0] word;
  logic [2:0] word_addr;
  logic [20:0] word_data;

  // register file
  logic [20:0] freq_r, freq_nxt;
  logic [20:0] ref_buf_r, ref_buf_nxt;
  logic [20:0] ref_act_r, ref_act_nxt;
  logic [20:0] phase_buf_r, phase_buf_nxt;
  logic [20:0] phase_act_r, phase_act_nxt;
  synth_loader_pkg::mux_sel_type mux_r, mux_nxt;
  logic [7:0] pump_timer_r, pump_timer_nxt;
  logic [7:0] switch_timer_r, switch_timer_nxt;
  logic [3:0] seen_r, seen_nxt;
  logic active_r, active_nxt;

  // fast lock
  synth_loader_pkg::fast_lock_type fl_r, fl_nxt;
  logic [7:0] fl_cnt_r, fl_cnt_nxt;
  logic [3:0] bw_r, bw_nxt;
  logic reduce_r, reduce_nxt;
  logic switch_r, switch_nxt;

  // status pin
  logic mux_out_r, mux_out_nxt;

  function automatic logic addr_is(input logic [2:0] a, input logic [2:0] code);
    addr_is = (a == code);
  endfunction

  // link side: only the shift register moves here
  always_comb begin
    shift_nxt = {shift_r[22:0], link.serial_data}; // R1 R13 R14
  end

  always_ff @(posedge link.serial_clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= 24'h000000;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // strobe filter: a change counts once flops two and three agree
  always_comb begin
    strobe_lvl_nxt = (strobe_sync_r[1] == strobe_sync_r[2]) ? strobe_sync_r[2] : strobe_lvl_r;
  end

  assign latch_pulse = strobe_lvl_nxt && !strobe_lvl_r; // R2
  // word is quasi-static: serial clock idles while strobe is high
  assign word = shift_r; // R2
  assign word_addr = word[`ADDR_MSB:`ADDR_LSB]; // R13
  assign word_data = word[`DATA_MSB:`DATA_LSB];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_sync_r <= 3'h7; // idle high, so release shows no rise
      strobe_lvl_r <= 1'b1;
    end else begin
      strobe_sync_r <= {strobe_sync_r[1:0], link.load_strobe};
      strobe_lvl_r <= strobe_lvl_nxt;
    end
  end

  // register writes, only on a strobe rise
  always_comb begin
    freq_nxt = freq_r;
    ref_buf_nxt = ref_buf_r;
    ref_act_nxt = ref_act_r;
    phase_buf_nxt = phase_buf_r;
    phase_act_nxt = phase_act_r;
    mux_nxt = mux_r;
    pump_timer_nxt = pump_timer_r;
    switch_timer_nxt = switch_timer_r;
    seen_nxt = seen_r;
    active_nxt = active_r;
    if (latch_pulse) begin // R14
      if (addr_is(word_addr, `ADDR_FREQUENCY)) begin
        freq_nxt = word_data;
        ref_act_nxt = ref_buf_r; // R12
        phase_act_nxt = phase_buf_r; // R12
        seen_nxt[0] = 1'b1;
        // live only once control, reference and phase were set
        active_nxt = active_r || (seen_r[3:1] == 3'h7); // R7
      end else if (addr_is(word_addr, `ADDR_REFERENCE)) begin
        ref_buf_nxt = word_data; // R12
        seen_nxt[1] = 1'b1;
      end else if (addr_is(word_addr, `ADDR_PHASE)) begin
        phase_buf_nxt = word_data; // R12
        seen_nxt[2] = 1'b1;
      end else if (addr_is(word_addr, `ADDR_CONTROL)) begin
        mux_nxt = synth_loader_pkg::mux_sel_type'(word[`CTL_MUX_MSB:`CTL_MUX_LSB]);
        pump_timer_nxt = word[`CTL_PUMP_MSB:`CTL_PUMP_LSB];
        switch_timer_nxt = word[`CTL_SWITCH_MSB:`CTL_SWITCH_LSB];
        seen_nxt[3] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      freq_r <= `RST_DATA;
      ref_buf_r <= `RST_DATA;
      ref_act_r <= `RST_DATA;
      phase_buf_r <= `RST_DATA;
      phase_act_r <= `RST_DATA;
      mux_r <= synth_loader_pkg::MUX_LOCK_DETECT;
      pump_timer_r <= `RST_PUMP_TIMER;
      switch_timer_r <= `RST_SWITCH_TIMER;
      seen_r <= 4'h0;
      active_r <= 1'b0;
    end else begin
      freq_r <= freq_nxt;
      ref_buf_r <= ref_buf_nxt;
      ref_act_r <= ref_act_nxt;
      phase_buf_r <= phase_buf_nxt;
      phase_act_r <= phase_act_nxt;
      mux_r <= mux_nxt;
      pump_timer_r <= pump_timer_nxt;
      switch_timer_r <= switch_timer_nxt;
      seen_r <= seen_nxt;
      active_r <= active_nxt;
    end
  end

  // fast lock: one count per sys_clk, standing in for a reference cycle
  always_comb begin
    fl_nxt = fl_r;
    fl_cnt_nxt = fl_cnt_r + 8'h01;
    bw_nxt = bw_r;
    reduce_nxt = reduce_r;
    switch_nxt = switch_r;
    case (fl_r)
      synth_loader_pkg::FL_IDLE: begin
        fl_cnt_nxt = 8'h00;
      end
      synth_loader_pkg::FL_WIDE: begin
        if (fl_cnt_r >= pump_timer_r) begin
          reduce_nxt = 1'b1; // R9
          fl_nxt = synth_loader_pkg::FL_REDUCED;
        end
      end
      synth_loader_pkg::FL_REDUCED: begin
        // switches open no earlier than the current cut
        if (fl_cnt_r >= switch_timer_r) begin
          switch_nxt = 1'b0; // R9 R10
          bw_nxt = `BW_FINAL; // R10
          fl_nxt = synth_loader_pkg::FL_IDLE;
        end
      end
      default: fl_nxt = synth_loader_pkg::FL_IDLE;
    endcase
    // a new frequency word restarts the sequence from any point
    if (latch_pulse && addr_is(word_addr, `ADDR_FREQUENCY)) begin
      fl_nxt = synth_loader_pkg::FL_WIDE; // R11
      fl_cnt_nxt = 8'h00;
      bw_nxt = `BW_FAST; // R10
      reduce_nxt = 1'b0;
      switch_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fl_r <= synth_loader_pkg::FL_IDLE;
      fl_cnt_r <= 8'h00;
      bw_r <= `BW_FINAL;
      reduce_r <= 1'b0;
      switch_r <= 1'b0;
    end else begin
      fl_r <= fl_nxt;
      fl_cnt_r <= fl_cnt_nxt;
      bw_r <= bw_nxt;
      reduce_r <= reduce_nxt;
      switch_r <= switch_nxt;
    end
  end

  // status pin selection
  always_comb begin
    case (mux_r)
      synth_loader_pkg::MUX_LOCK_DETECT: mux_out_nxt = lock_detect_in && active_r; // R8
      synth_loader_pkg::MUX_FAST_LOCK: mux_out_nxt = (fl_r != synth_loader_pkg::FL_IDLE);
      synth_loader_pkg::MUX_DRIVE_HIGH: mux_out_nxt = 1'b1;
      default: mux_out_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mux_out_r <= 1'b0;
    end else begin
      mux_out_r <= mux_out_nxt;
    end
  end

  assign link.multiplexed_output = mux_out_r; // R8
  assign frequency_word = freq_r;
  assign reference_word = ref_act_r;
  assign phase_word = phase_act_r;
  assign fast_lock_active = (fl_r != synth_loader_pkg::FL_IDLE);
  assign pump_current_reduced = reduce_r;
  // switches closed means wide bandwidth
  assign filter_switch_one = switch_r;
  assign filter_switch_two = switch_r;
  assign filter_switch_three = switch_r;
  assign bandwidth_factor = bw_r;
  assign output_active = active_r; // R7
endmodule // synth_loader_device
`default_nettype wire

//--- verilog/synth_loader_cfg.svh
/*
  Constants for the synthesizer serial word loader: word layout,
  register address codes, reset values and timing counts.
  Assumes inclusion by bare name from the device and host design files.
*/
`ifndef SYNTH_LOADER_CFG_SVH
`define SYNTH_LOADER_CFG_SVH

// serial word
`define WORD_BITS 24
`define BYTE_BITS 8
`define ADDR_LSB 0
`define ADDR_MSB 2
`define DATA_LSB 3
`define DATA_MSB 23

// address codes in the low bits of the word
`define ADDR_FREQUENCY 3'h0
`define ADDR_REFERENCE 3'h1
`define ADDR_PHASE 3'h2
`define ADDR_CONTROL 3'h3

// control word fields
`define CTL_MUX_LSB 3
`define CTL_MUX_MSB 4
`define CTL_PUMP_LSB 5
`define CTL_PUMP_MSB 12
`define CTL_SWITCH_LSB 13
`define CTL_SWITCH_MSB 20

// reset values
`define RST_PUMP_TIMER 8'h1C
`define RST_SWITCH_TIMER 8'h23
`define RST_DATA 21'h000000

// loop bandwidth factors
`define BW_FAST 4'h8
`define BW_FINAL 4'h1

// link timing, host side
`define SYS_CLK_NS 100
`define SERIAL_MAX_MHZ 33
`define HALF_PERIOD_CYCLES 2
`define STROBE_HIGH_CYCLES 4

`endif

//--- verilog/synth_loader_pkg.sv
/*
  Types shared by both ends of the serial word loader.
  Assumes the constants header is on the include path.
*/
`default_nettype none
package synth_loader_pkg;

  // what the multiplexed output pin carries
  typedef enum logic [1:0] {
    MUX_LOCK_DETECT,
    MUX_FAST_LOCK,
    MUX_DRIVE_LOW,
    MUX_DRIVE_HIGH
  } mux_sel_type;

  // fast-lock sequence
  typedef enum logic [1:0] {
    FL_IDLE,
    FL_WIDE,
    FL_REDUCED
  } fast_lock_type;

  // host transfer sequence
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_LEAD,
    HS_SHIFT,
    HS_TRAIL,
    HS_LATCH
  } host_state_type;

endpackage
`default_nettype wire

//--- verilog/synth_link_if.sv
/*
  Three-wire serial link plus the multiplexed status pin.
  Assumes the host makes the serial clock; the device returns status.
*/
`timescale 1ns/1ps
`default_nettype none
interface synth_link_if;
  logic serial_clk;
  logic serial_data;
  logic load_strobe;
  logic multiplexed_output;

  modport device (
    input serial_clk,
    input serial_data,
    input load_strobe,
    output multiplexed_output
  );

  modport host (
    output serial_clk,
    output serial_data,
    output load_strobe,
    input multiplexed_output
  );
endinterface
`default_nettype wire

//--- verilog/synth_loader_host.sv
/*
  Serial master end: sends an init sequence after reset, then words
  from the command port as three bytes, MSB first, strobe last.
  Assumes sys_clk is free running; makes the serial clock by division.
*/
`timescale 1ns/1ps
`default_nettype none
`include "synth_loader_cfg.svh"
module synth_loader_host (
  input wire logic sys_clk,
  input wire logic resetn,
  synth_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [23:0] cmd_word,
  output logic cmd_ready,
  output logic init_done,
  output logic lock_status
);
  synth_loader_pkg::host_state_type state_r, state_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [2:0] tick_r, tick_nxt;
  logic [23:0] word_r, word_nxt;
  logic [2:0] init_r, init_nxt;
  logic sclk_r, sclk_nxt;
  logic sdata_r, sdata_nxt;
  logic strobe_r, strobe_nxt;
  logic [2:0] sync_r;
  logic lock_r, lock_nxt;
  logic tick_end;

  // init words: control, reference, phase, then frequency last
  function automatic logic [23:0] init_word(input logic [2:0] idx);
    case (idx)
      3'h0: init_word = {3'h0, `RST_SWITCH_TIMER, `RST_PUMP_TIMER, 2'h0, `ADDR_CONTROL};
      3'h1: init_word = {21'h000001, `ADDR_REFERENCE};
      3'h2: init_word = {21'h000000, `ADDR_PHASE};
      default: init_word = {21'h000100, `ADDR_FREQUENCY};
    endcase
  endfunction

  assign tick_end = (tick_r == 3'(`HALF_PERIOD_CYCLES - 1));
  assign init_done = (init_r == 3'h4);
  assign cmd_ready = init_done && (state_r == synth_loader_pkg::HS_IDLE);
  assign link.serial_clk = sclk_r;
  assign link.serial_data = sdata_r;
  assign link.load_strobe = strobe_r;
  assign lock_status = lock_r;

  // transfer sequencer
  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    tick_nxt = tick_end ? 3'h0 : tick_r + 3'h1;
    word_nxt = word_r;
    init_nxt = init_r;
    sclk_nxt = sclk_r;
    sdata_nxt = sdata_r;
    strobe_nxt = strobe_r;
    case (state_r)
      synth_loader_pkg::HS_IDLE: begin
        tick_nxt = 3'h0;
        if (!init_done) begin
          word_nxt = init_word(init_r); // R7
          init_nxt = init_r + 3'h1;
          state_nxt = synth_loader_pkg::HS_LEAD;
        end else if (cmd_valid) begin
          word_nxt = cmd_word;
          state_nxt = synth_loader_pkg::HS_LEAD;
        end
      end
      synth_loader_pkg::HS_LEAD: begin
        strobe_nxt = 1'b0; // R4
        if (tick_end) begin
          sdata_nxt = word_r[23]; // R6
          word_nxt = {word_r[22:0], 1'b0};
          bit_nxt = 5'h0;
          state_nxt = synth_loader_pkg::HS_SHIFT;
        end
      end
      synth_loader_pkg::HS_SHIFT: begin
        if (tick_end) begin
          sclk_nxt = !sclk_r; // R3
          if (sclk_r) begin
            // data moves on the falling edge, stable for the rise
            if (bit_r == 5'(`WORD_BITS - 1)) begin
              state_nxt = synth_loader_pkg::HS_TRAIL; // R5
            end else begin
              sdata_nxt = word_r[23]; // R6
              word_nxt = {word_r[22:0], 1'b0};
              bit_nxt = bit_r + 5'h1;
            end
          end
        end
      end
      synth_loader_pkg::HS_TRAIL: begin
        if (tick_end) begin
          strobe_nxt = 1'b1; // R5
          bit_nxt = 5'h0;
          state_nxt = synth_loader_pkg::HS_LATCH;
        end
      end
      synth_loader_pkg::HS_LATCH: begin
        // strobe stays high long enough for the device synchroniser
        tick_nxt = 3'h0;
        bit_nxt = bit_r + 5'h1;
        if (bit_r == 5'(`STROBE_HIGH_CYCLES - 1)) begin
          state_nxt = synth_loader_pkg::HS_IDLE;
        end
      end
      default: state_nxt = synth_loader_pkg::HS_IDLE;
    endcase
    // three-flop filter on the status pin
    lock_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : lock_r;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= synth_loader_pkg::HS_IDLE;
      bit_r <= 5'h0;
      tick_r <= 3'h0;
      word_r <= 24'h000000;
      init_r <= 3'h0;
      sclk_r <= 1'b0;
      sdata_r <= 1'b0;
      strobe_r <= 1'b1;
      sync_r <= 3'h0;
      lock_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      tick_r <= tick_nxt;
      word_r <= word_nxt;
      init_r <= init_nxt;
      sclk_r <= sclk_nxt;
      sdata_r <= sdata_nxt;
      strobe_r <= strobe_nxt;
      sync_r <= {sync_r[1:0], link.multiplexed_output};
      lock_r <= lock_nxt;
    end
  end
endmodule // synth_loader_host
`default_nettype wire

//--- verif/synth_link_assertions.sv
/*
  wire checker for the host-to-device serial link.
  assumes both ends share sys_clk and resetn.
*/
`timescale 1ns/1ps
`default_nettype none
module synth_link_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic multiplexed_output
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [5:0] bits_r, bits_nxt;
  logic [2:0] words_r, words_nxt;
  logic clk_d_r, stb_d_r;
  // rises per frame; strobe rises since reset, saturating at the init count
  always_comb begin
    bits_nxt = load_strobe ? 6'h00 : bits_r + {5'h00, serial_clk & ~clk_d_r};
    words_nxt = words_r + {2'h0, load_strobe & ~stb_d_r & (words_r != 3'h4)};
  end
  // strobe history starts high, matching its idle level
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bits_r <= 6'h00;
      words_r <= 3'h0;
      clk_d_r <= 1'b0;
      stb_d_r <= 1'b1;
    end else begin
      bits_r <= bits_nxt;
      words_r <= words_nxt;
      clk_d_r <= serial_clk;
      stb_d_r <= load_strobe;
    end
  end
  a_shift_needs_low: assert property ($rose(serial_clk) |-> !load_strobe)
    else $error("serial clock rose with strobe high");
  a_lead_before_clock: assert property ($fell(load_strobe) |-> !serial_clk [*2])
    else $error("no quiet lead after strobe fell");
  a_word_is_24: assert property ($rose(load_strobe) |-> bits_r == 6'h18)
    else $error("frame did not hold 24 bits");
  a_clock_still_latched: assert property (load_strobe |-> !serial_clk)
    else $error("serial clock moved while strobe high");
  a_strobe_held: assert property ($rose(load_strobe) |-> load_strobe [*4])
    else $error("strobe high too short to latch");
  a_data_steady_rise: assert property ($rose(serial_clk) |-> $stable(serial_data))
    else $error("data changed at the sampling edge");
  a_clock_high_half: assert property ($rose(serial_clk) |=> serial_clk)
    else $error("serial clock high half too short");
  a_clock_low_half: assert property ($fell(serial_clk) |=> !serial_clk)
    else $error("serial clock low half too short");
  a_quiet_before_init: assert property (words_r < 3'h4 |-> !multiplexed_output)
    else $error("status pin active before init");
  c_latch: cover property ($rose(load_strobe));
  c_one_bit: cover property ($rose(serial_clk) && serial_data);
  c_status_up: cover property (words_r == 3'h4 ##1 multiplexed_output);
endmodule // synth_link_assertions
`default_nettype wire

//--- verif/tb_top.sv
/*
  top bench: host and device joined by the link, plus a second device
  fed bit by bit from the bench with frames that break the host rules.
  assumes one sys_clk for both ends; the raw link clock is made here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, resetn, cmd_valid, cmd_ready, init_done, lock_status, lock_in;
  logic [23:0] cmd_word;
  logic [20:0] freq_w, ref_w, phase_w, raw_freq;
  logic fl_act, pump_red, sw1, sw2, sw3, out_act;
  logic [3:0] bw;
  int miscompares, n_compared, cycles;
  synth_link_if link ();
  synth_link_if raw ();
  synth_loader_host u_synth_loader_host (.sys_clk(sys_clk), .resetn(resetn), .link(link),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
    .init_done(init_done), .lock_status(lock_status));
  synth_loader_device u_synth_loader_device (.sys_clk(sys_clk), .resetn(resetn),
    .link(link), .lock_detect_in(lock_in), .frequency_word(freq_w),
    .reference_word(ref_w), .phase_word(phase_w), .fast_lock_active(fl_act),
    .pump_current_reduced(pump_red), .filter_switch_one(sw1), .filter_switch_two(sw2),
    .filter_switch_three(sw3), .bandwidth_factor(bw), .output_active(out_act));
  synth_loader_device u_synth_loader_device_raw (.sys_clk(sys_clk), .resetn(resetn),
    .link(raw), .lock_detect_in(lock_in), .frequency_word(raw_freq), .reference_word(),
    .phase_word(), .fast_lock_active(), .pump_current_reduced(), .filter_switch_one(),
    .filter_switch_two(), .filter_switch_three(), .bandwidth_factor(), .output_active());
  synth_link_assertions u_synth_link_assertions (.sys_clk(sys_clk), .resetn(resetn),
    .serial_clk(link.serial_clk), .serial_data(link.serial_data),
    .load_strobe(link.load_strobe), .multiplexed_output(link.multiplexed_output));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // hang guard, far above the less than two thousand cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({23'h000000, got}, {23'h000000, exp});
  endtask
  // waits out a transfer plus register settling
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 2000);
    if (cmd_ready !== 1'b1) begin
      miscompares++;
      final_report();
    end
    repeat (3) @(negedge sys_clk);
  endtask
  // returns at the take edge so fast lock can be watched from there
  task automatic send(input logic [23:0] w);
    wait_ready();
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask
  function automatic logic [23:0] ctl(input logic [1:0] m);
    return {3'h0, 8'h09, 8'h04, m, 3'h3};
  endfunction
  task automatic set_lock(input logic v);
    @(posedge sys_clk);
    lock_in <= v;
    repeat (8) @(negedge sys_clk);
  endtask
  // raw link clock at 15 ns, still outside the frame
  task automatic raw_shift(input logic [27:0] v);
    @(posedge sys_clk);
    raw.load_strobe <= 1'b0;
    #20;
    for (int i = 27; i >= 0; i--) begin
      raw.serial_data = v[i];
      #7.5 raw.serial_clk = 1'b1;
      #7.5 raw.serial_clk = 1'b0;
    end
    raw.serial_data = ~v[0];
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic raw_latch();
    @(posedge sys_clk);
    raw.load_strobe <= 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
  initial begin
    logic [20:0] ref_old, ph_old;
    int t0, t1, t2;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 24'h000000;
    lock_in = 1'b0;
    raw.serial_clk = 1'b0;
    raw.serial_data = 1'b0;
    raw.load_strobe = 1'b1;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk_bit(out_act, 1'b0);
    wait_ready();
    chk_bit(init_done, 1'b1);
    chk_bit(out_act, 1'b1);
    // every status source, lock high then low; fast-lock busy is idle here
    for (int m = 0; m < 4; m++) begin
      send(ctl(m[1:0]));
      wait_ready();
      set_lock(1'b1);
      chk_bit(link.multiplexed_output, m == 0 || m == 3);
      chk_bit(lock_status, m == 0 || m == 3);
      set_lock(1'b0);
      chk_bit(link.multiplexed_output, m == 3);
    end
    // fast-lock busy on the pin for the frequency write below
    send(ctl(2'h1));
    ref_old = ref_w;
    ph_old = phase_w;
    send({21'h012345, 3'h1});
    send({21'h00ABCD, 3'h2});
    wait_ready();
    chk_word({3'h0, ref_w}, {3'h0, ref_old});
    chk_word({3'h0, phase_w}, {3'h0, ph_old});
    send({21'h1F0F0F, 3'h0});
    t0 = -1;
    t1 = -1;
    t2 = -1;
    for (int n = 0; n < 400; n++) begin
      @(negedge sys_clk);
      if (fl_act === 1'b1 && t0 < 0) begin
        t0 = n;
        chk_word({20'h00000, bw}, 24'h000008);
        chk_bit(pump_red, 1'b0);
        chk_bit(sw1 & sw2 & sw3, 1'b1);
        chk_word({3'h0, freq_w}, 24'h1F0F0F);
        chk_word({3'h0, ref_w}, 24'h012345);
        chk_word({3'h0, phase_w}, 24'h00ABCD);
      end
      if (t0 >= 0 && pump_red === 1'b1 && t1 < 0) t1 = n;
      if (t0 >= 0 && n == t0 + 2) chk_bit(link.multiplexed_output, 1'b1);
      if (t0 >= 0 && sw1 === 1'b0 && t2 < 0) t2 = n;
    end
    chk_bit(t1 > t0, 1'b1);
    chk_word(24'(t2 - t1), 24'h000005);
    chk_word({20'h00000, bw}, 24'h000001);
    chk_bit(sw2 | sw3, 1'b0);
    chk_bit(link.multiplexed_output, 1'b0);
    // four stale bits lead the frame and must fall off the top
    raw_shift({4'hA, 21'h0C3A5A, 3'h0});
    chk_word({3'h0, raw_freq}, 24'h000000);
    raw_latch();
    chk_word({3'h0, raw_freq}, 24'h0C3A5A);
    raw_shift({4'h5, 21'h015555, 3'h5});
    raw_latch();
    chk_word({3'h0, raw_freq}, 24'h0C3A5A);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
